//--- tb/sbtc_asserts.sv
// port-level checker for the timer counter, bound to its top
module sbtc_asserts
  import sbtc_pkg::*;
(
  input wire logic              clk,                 // clock
  input wire logic              sys_rst,             // sync reset
  input wire logic              psel,                // select
  input wire logic              penable,             // access phase
  input wire logic              pwrite,              // write
  input wire logic [ADDR_W-1:0] paddr,               // address
  input wire logic [DATA_W-1:0] pwdata,              // write data
  input wire logic [DATA_W-1:0] prdata,              // read data
  input wire logic              pslverr,             // error
  input wire logic [1:0]        port_direction_bits, // port dirs
  input wire logic [1:0]        pin_oe,              // pin enables
  input wire logic [1:0]        port_read_data,      // port view
  input wire logic              osc_inverter_on,     // osc power
  input wire logic              irq                  // request
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic wr_acc;   // write access edge
  logic rd_setup; // read setup edge
  logic mapped;   // address decodes
  logic ie;       // shadow of the enable bit
  assign wr_acc = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign mapped = paddr inside {COUNT_LOW_OFS, COUNT_HIGH_OFS, FLAG_OFS,
                                FLAG_CLR_OFS, CTRL_OFS, ENABLE_OFS};
  ////////////////////////////////////////////////////////////////////////
  // enable shadow, so the request can be judged without the flag
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ie <= 1'h0;
    end else if (wr_acc && paddr == ENABLE_OFS) begin
      ie <= pwdata[OVF_IE_BIT];
    end
  end
  ////////////////////////////////////////////////////////////////////////
  property p_irq_gated;
    irq |-> ie;
  endproperty
  a_irq_gated: assert property (p_irq_gated)
    else $error("irq high while disabled");
  property p_irq_mask;
    wr_acc && paddr == ENABLE_OFS && !pwdata[0] |=> !irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("irq not masked");
  property p_slverr;
    psel && penable |-> pslverr == !mapped;
  endproperty
  a_slverr: assert property (p_slverr)
    else $error("wrong error response");
  property p_osc_pins;
    osc_inverter_on |-> port_read_data == 2'h0 && pin_oe == 2'h0;
  endproperty
  a_osc_pins: assert property (p_osc_pins)
    else $error("pins not inputs reading zero");
  property p_osc_off;
    !osc_inverter_on |-> pin_oe == ~port_direction_bits;
  endproperty
  a_osc_off: assert property (p_osc_off)
    else $error("pin enables ignore direction");
  property p_osc_write;
    wr_acc && paddr == CTRL_OFS |=> osc_inverter_on == $past(pwdata[3]);
  endproperty
  a_osc_write: assert property (p_osc_write)
    else $error("oscillator power not following control");
  property p_reset;
    $fell(sys_rst) |-> !irq && !osc_inverter_on && prdata == '0;
  endproperty
  a_reset: assert property (p_reset)
    else $error("outputs not cleared by reset");
  property p_ctrl_hi0;
    rd_setup && paddr == CTRL_OFS |=> prdata[DATA_W-1:CTRL_W] == '0;
  endproperty
  a_ctrl_hi0: assert property (p_ctrl_hi0)
    else $error("unimplemented control bits not zero");
  c_irq: cover property (irq);
  c_err: cover property (psel && penable && pslverr);
  c_osc: cover property (osc_inverter_on);
endmodule

bind sbtc_timer sbtc_asserts u_chk (.clk, .sys_rst, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pslverr, .port_direction_bits,
  .pin_oe, .port_read_data, .osc_inverter_on, .irq);

//--- tb/sbtc_ext_src.sv
// external clock source model: square wave on a pin, still when idle
module sbtc_ext_src #(
  parameter int HALF = 3         // cycles per half period
) (
  input  wire logic clk,         // bench clock
  input  wire logic run,         // toggle while high
  input  wire logic idle_lvl,    // level held between bursts
  output logic      lvl          // pin level
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;                   // cycles in this half
  initial lvl = 1'h0;
  // toggles from the idle level, so the first edge is its inverse
  always @(posedge clk) begin
    if (!run) begin
      lvl <= idle_lvl;
      cnt <= 0;
    end else if (cnt == HALF - 1) begin
      lvl <= !lvl;
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

//--- tb/sixteen_bit_timer_counter_tb.sv
// self-checking bench for the sixteen bit timer counter
module sixteen_bit_timer_counter_tb;
  import sbtc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0]  a;              // address
    logic [31:0] w;              // written
    logic [31:0] r;              // read back
    logic        e;              // error expected
  } sbtc_row_s;
  sbtc_row_s rows [9] = '{
    '{COUNT_LOW_OFS, 32'h5A, 32'h5A, 1'h0},
    '{COUNT_HIGH_OFS, 32'hA5, 32'hA5, 1'h0},
    '{CTRL_OFS, 32'hFE, 32'h3E, 1'h0},
    '{CTRL_OFS, 32'h00, 32'h00, 1'h0},
    '{FLAG_OFS, 32'h01, 32'h00, 1'h0},
    '{FLAG_CLR_OFS, 32'h01, 32'h00, 1'h0},
    '{ENABLE_OFS, 32'h01, 32'h01, 1'h0},
    '{ENABLE_OFS, 32'h00, 32'h00, 1'h0},
    '{8'h18, 32'hFF, 32'h00, 1'h1}};
  logic [7:0] tc [5] = '{8'h01, 8'h11, 8'h21, 8'h31, 8'h05}; // timer
  logic [7:0] cc [4] = '{8'h07, 8'h03, 8'h13, 8'h0F}; // counter
  int ce [4] = '{10, 10, 5, 10};  // rises counted per config
  logic clk = 1'h0, sys_rst = 1'h1;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0, prdata, rd, held;
  logic pready, pslverr, irq, osc_on, err, lvl;
  logic run = 1'h0, idle = 1'h0, pin_sel = 1'h0;
  logic [1:0] pin_out, pin_oe, prd;
  sbtc_trig_s trig_a = '0, trig_b = '0;
  int err_count = 0, num_checks = 0;
  wire logic pin1 = pin_sel ? lvl : 1'h0;  // oscillator input pin
  wire logic pin0 = pin_sel ? 1'h0 : lvl;  // external clock pin
  initial forever #2 clk = ~clk;
  sbtc_timer dut (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .osc_input_pin(pin1), .osc_output_ext_clock_pin(pin0),
    .port_direction_bits(2'h3), .port_out_data(2'h0), .pin_out(pin_out),
    .pin_oe(pin_oe), .port_read_data(prd), .osc_inverter_on(osc_on),
    .capture_compare_unit_a(trig_a), .capture_compare_unit_b(trig_b),
    .irq(irq));
  sbtc_ext_src u_src (.clk(clk), .run(run), .idle_lvl(idle), .lvl(lvl));
  ////////////////////////////////////////////////////////////////////////
  task automatic check(string n, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // phase of the divide-by-four is free, so allow one count either way
  task automatic check_near(string n, int e, logic [31:0] g);
    num_checks++;
    if (g + 1 >= e && g <= e + 1) begin
    end else begin
      err_count++;
      $display("[FAIL] %s expected %0d seen %0d", n, e, g);
    end
  endtask
  // one apb transfer; ev fires a special event in the access cycle
  task automatic xfer(logic w, logic [7:0] a, logic [31:0] d,
                      logic ev = 1'h0);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    if (ev) trig_a <= '{SPECIAL_EVENT_MODE, 1'h1};
    do @(posedge clk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    trig_a <= '0;
  endtask
  task automatic rdchk(logic [7:0] a, logic [31:0] e, string n);
    xfer(1'h0, a, '0);
    check(n, e, rd);
  endtask
  task automatic fire(logic b, logic [3:0] m);
    @(posedge clk);
    if (b) trig_b <= '{m, 1'h1};
    else trig_a <= '{m, 1'h1};
    @(posedge clk);
    trig_a <= '0;
    trig_b <= '0;
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    complete_run();
  end
  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'h0;
    rdchk(CTRL_OFS, 0, "ctrl reset");
    rdchk(COUNT_LOW_OFS, 0, "count reset");
    foreach (rows[i]) begin
      xfer(1'h1, rows[i].a, rows[i].w);
      check("write error", rows[i].e, err);
      xfer(1'h0, rows[i].a, '0);
      check("read back", rows[i].r, rd);
    end
    foreach (tc[i]) begin
      xfer(1'h1, COUNT_LOW_OFS, 0);
      xfer(1'h1, CTRL_OFS, tc[i]);
      repeat (256) @(posedge clk);
      xfer(1'h1, CTRL_OFS, 0);
      xfer(1'h0, COUNT_LOW_OFS, 0);
      check_near("timer count", 64 >> tc[i][5:4], rd);
    end
    held = rd;
    repeat (20) @(posedge clk);
    rdchk(COUNT_LOW_OFS, held, "stopped count");
    xfer(1'h1, COUNT_HIGH_OFS, 32'hFF);
    xfer(1'h1, COUNT_LOW_OFS, 32'hF8);
    xfer(1'h1, CTRL_OFS, 1);
    repeat (60) @(posedge clk);
    xfer(1'h1, CTRL_OFS, 0);
    check("irq masked", 0, irq);
    rdchk(FLAG_OFS, 1, "overflow flag");
    rdchk(COUNT_HIGH_OFS, 0, "wrapped high");
    xfer(1'h1, ENABLE_OFS, 1);
    @(posedge clk);
    check("irq raised", 1, irq);
    rdchk(FLAG_OFS, 1, "flag sticks");
    xfer(1'h1, FLAG_CLR_OFS, 1);
    @(posedge clk);
    check("irq cleared", 0, irq);
    xfer(1'h1, COUNT_HIGH_OFS, 32'h12);
    fire(1'h0, SPECIAL_EVENT_MODE);
    rdchk(COUNT_HIGH_OFS, 0, "event clear");
    rdchk(FLAG_OFS, 0, "event no flag");
    xfer(1'h1, COUNT_LOW_OFS, 32'h34);
    fire(1'h1, 4'hA);
    rdchk(COUNT_LOW_OFS, 32'h34, "other mode");
    fire(1'h1, SPECIAL_EVENT_MODE);
    rdchk(COUNT_LOW_OFS, 0, "unit b clear");
    xfer(1'h1, COUNT_LOW_OFS, 32'h77, 1'h1);
    rdchk(COUNT_LOW_OFS, 32'h77, "write wins");
    foreach (cc[i]) begin
      idle <= 1'h0;
      pin_sel <= cc[i][3];
      xfer(1'h1, COUNT_LOW_OFS, 0);
      xfer(1'h1, CTRL_OFS, cc[i]);
      idle <= 1'h1;  // lone rise before any fall: not counted
      repeat (8) @(posedge clk);
      run <= 1'h1;
      repeat (60) @(posedge clk);
      run <= 1'h0;
      repeat (8) @(posedge clk);
      xfer(1'h1, CTRL_OFS, 0);
      rdchk(COUNT_LOW_OFS, ce[i], "edges counted");
    end
    check("pin out", 0, pin_out);
    check("port read", {pin1, pin0}, prd);
    complete_run();
  end
endmodule

//--- verilog/sbtc_pkg.sv
// package of constants and types for the sixteen bit timer counter
// How it works
// - 16-bit count, two RW bytes, wraps
// - wrap to zero sets overflow flag bit 0
// - interrupt only while enable bit 0 set
// - control bit 1 picks timer or counter
// - timer mode counts oscillator divided by four
// - counter mode counts external rising edges only
// - control bit 0 runs or holds count
// - counter waits for one falling edge first
// - either compare unit can clear the count
// - bits 5:4 prescale 1,2,4,8
// - oscillator on: pins inputs, read zero
// - active-low sync bit matters in counter mode
// - sync after prescaler; prescaler runs ahead
// - special event code 1011 clears, no flag
// - count write beats special event clear
package sbtc_pkg;

  //////////////////////////////////////////////////////////////////////////
  // bus geometry
  localparam int ADDR_W = 8;                     // apb byte address width
  localparam int DATA_W = 32;                    // apb data width

  //////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [ADDR_W-1:0] COUNT_LOW_OFS  = 8'h00; // count low byte
  localparam logic [ADDR_W-1:0] COUNT_HIGH_OFS = 8'h04; // count high byte
  localparam logic [ADDR_W-1:0] FLAG_OFS       = 8'h08; // sticky flags, ro
  localparam logic [ADDR_W-1:0] FLAG_CLR_OFS   = 8'h0C; // flag clear, wo
  localparam logic [ADDR_W-1:0] CTRL_OFS       = 8'h10; // timer_control
  localparam logic [ADDR_W-1:0] ENABLE_OFS     = 8'h14; // interrupt enable

  //////////////////////////////////////////////////////////////////////////
  // field positions and reset values
  localparam int CTRL_W     = 6;                 // implemented control bits
  localparam int OVF_BIT    = 0;                 // overflow flag position
  localparam int OVF_IE_BIT = 0;                 // overflow enable position
  localparam int BYTE_W     = 8;                 // width of one count byte
  localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00; // all control cleared

  //////////////////////////////////////////////////////////////////////////
  // counting constants
  localparam int COUNT_W = 16;                   // count width
  localparam logic [COUNT_W-1:0] COUNT_ZERO = 16'h0000; // wrap target
  localparam logic [COUNT_W-1:0] COUNT_MAX  = 16'hFFFF; // last value
  localparam int INSTR_DIV_W = 2;                // divide by four counter
  localparam logic [INSTR_DIV_W-1:0] INSTR_LAST = 2'h3; // fourth phase
  localparam int PRESC_W = 3;                    // ripple stages, max 1:8
  localparam logic [3:0] SPECIAL_EVENT_MODE = 4'hB; // compare, reset timer

  //////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [1:0] {
    SBTC_PS_1 = 2'h0,                            // no division
    SBTC_PS_2 = 2'h1,                            // 1:2
    SBTC_PS_4 = 2'h2,                            // 1:4
    SBTC_PS_8 = 2'h3                             // 1:8
  } sbtc_prescale_e;

  // control register layout, bit 0 at the bottom
  typedef struct packed {
    sbtc_prescale_e prescale_select;             // bits 5:4
    logic           osc_enable;                  // bit 3
    logic           sync_disable_n;              // bit 2, 1 = no sync
    logic           clock_source_select;         // bit 1, 1 = external
    logic           counter_on;                  // bit 0
  } sbtc_ctrl_s;

  // one capture/compare unit's view of the timer reset
  typedef struct packed {
    logic [3:0] mode;                            // unit mode code
    logic       match;                           // compare match pulse
  } sbtc_trig_s;

endpackage

//--- verilog/sbtc_prescaler.sv
// input prescaler: counts input ticks, passes one of each 1, 2, 4 or 8
module sbtc_prescaler
  import sbtc_pkg::*;
(
  input  wire logic           clk,               // system clock
  input  wire logic           sys_rst,           // sync reset, high
  input  wire logic           clear,             // restart the division
  input  wire logic           tick_in,           // one-cycle input event
  input  wire sbtc_prescale_e select,            // division ratio
  output logic                tick_out           // registered output pulse
);

  logic [PRESC_W-1:0] stage;                     // ripple counter image
  logic               carry;                     // selected stage rolls

  //////////////////////////////////////////////////////////////////////////
  // pick the stage whose rollover ends a divided period
  always_comb begin
    carry = 1'b0;
    unique case (select)
      SBTC_PS_1: carry = tick_in;
      SBTC_PS_2: carry = tick_in & (&stage[0:0]);
      SBTC_PS_4: carry = tick_in & (&stage[1:0]);
      SBTC_PS_8: carry = tick_in & (&stage[2:0]);
    endcase
  end

  // the counter runs on input ticks alone, ahead of any sync stage
  always_ff @(posedge clk) begin
    if (sys_rst || clear) begin
      stage <= '0;
    end else if (tick_in) begin
      stage <= stage + 1'b1;
    end
  end

  // output is a flop so the sync stage sees a clean pulse
  always_ff @(posedge clk) begin
    if (sys_rst || clear) begin
      tick_out <= 1'b0;
    end else begin
      tick_out <= carry;
    end
  end

endmodule

//--- verilog/sbtc_timer.sv
// sixteen bit timer counter with apb registers and oscillator pins
module sbtc_timer
  import sbtc_pkg::*;
(
  input  wire logic              clk,                // oscillator clock
  input  wire logic              sys_rst,            // sync reset, high
  // apb slave
  input  wire logic              psel,               // slave select
  input  wire logic              penable,            // access phase
  input  wire logic              pwrite,             // 1 = write
  input  wire logic [ADDR_W-1:0] paddr,              // byte address
  input  wire logic [DATA_W-1:0] pwdata,             // write data
  output logic      [DATA_W-1:0] prdata,             // read data, flopped
  output logic                   pready,             // always ready
  output logic                   pslverr,            // unmapped address
  // oscillator / external clock pins
  input  wire logic              osc_input_pin,      // pin 1 level in
  input  wire logic              osc_output_ext_clock_pin, // pin 0 in
  input  wire logic [1:0]        port_direction_bits,// 1 = port input
  input  wire logic [1:0]        port_out_data,      // port drive value
  output logic      [1:0]        pin_out,            // pin drive values
  output logic      [1:0]        pin_oe,             // pin drive enables
  output logic      [1:0]        port_read_data,     // port read view
  output logic                   osc_inverter_on,    // oscillator power
  // capture/compare units
  input  wire sbtc_trig_s        capture_compare_unit_a, // unit a
  input  wire sbtc_trig_s        capture_compare_unit_b, // unit b
  // interrupt
  output logic                   irq                 // overflow request
);

  //////////////////////////////////////////////////////////////////////////
  // declarations
  sbtc_ctrl_s            ctrl;                   // timer_control
  logic                  overflow_flag;          // sticky overflow
  logic                  overflow_interrupt_enable; // mask bit
  logic [COUNT_W-1:0]    count;                  // count pair
  logic [COUNT_W-1:0]    next_count;             // count after this edge
  logic [INSTR_DIV_W-1:0] instr_phase;           // divide by four
  logic                  instr_tick;             // one per instr cycle
  logic                  ext_level;              // selected clock pin
  logic                  ext_prev;               // pin level last cycle
  logic                  ext_rise;               // rising edge seen
  logic                  ext_fall;               // falling edge seen
  logic                  fall_seen;              // arm after falling edge
  logic                  counter_mode_on;        // running on ext clock
  logic                  presc_in;               // prescaler input tick
  logic                  presc_out;              // prescaler output tick
  logic                  presc_clear;            // restart prescaler
  logic                  sync_a;                 // sync stage one
  logic                  sync_b;                 // sync stage two
  logic                  use_async;              // skip the sync stage
  logic                  count_tick;             // advance this cycle
  logic                  wraps;                  // ffff to 0000 now
  logic                  trig_any;               // special event seen
  logic                  trig_reset;             // clear actually applied
  logic                  wr_en;                  // write access edge
  logic                  rd_setup;               // read setup cycle
  logic                  wr_low;                 // write low byte
  logic                  wr_high;                // write high byte
  logic                  wr_count;               // either count byte
  logic                  mapped;                 // address decodes
  logic [DATA_W-1:0]     rd_value;               // read mux output

  //////////////////////////////////////////////////////////////////////////
  // apb decode: zero wait states, every access ends in its first
  // access cycle
  assign pready   = 1'b1;
  assign wr_en    = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;

  // any of the six word addresses is mapped
  always_comb begin
    mapped = 1'b0;
    unique case (paddr)
      COUNT_LOW_OFS, COUNT_HIGH_OFS, FLAG_OFS,
      FLAG_CLR_OFS, CTRL_OFS, ENABLE_OFS: mapped = 1'b1;
      default: mapped = 1'b0;            // unmapped word or odd address
    endcase
  end

  // error only in the access phase, so the master samples it with pready
  assign pslverr = psel & penable & ~mapped;

  assign wr_low   = wr_en & (paddr == COUNT_LOW_OFS);
  assign wr_high  = wr_en & (paddr == COUNT_HIGH_OFS);
  assign wr_count = wr_low | wr_high;

  //////////////////////////////////////////////////////////////////////////
  // control register, cleared by reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl <= sbtc_ctrl_s'(CTRL_RESET);
    end else if (wr_en && paddr == CTRL_OFS) begin
      ctrl <= sbtc_ctrl_s'(pwdata[CTRL_W-1:0]);  // bits 7:6 not stored
    end
  end

  // interrupt enable register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      overflow_interrupt_enable <= 1'b0;
    end else if (wr_en && paddr == ENABLE_OFS) begin
      overflow_interrupt_enable <= pwdata[OVF_IE_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // instruction clock: one enable pulse every fourth clk
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      instr_phase <= '0;
    end else begin
      instr_phase <= instr_phase + 1'b1;
    end
  end

  assign instr_tick = (instr_phase == INSTR_LAST);

  //////////////////////////////////////////////////////////////////////////
  // external clock: with the oscillator on the input side pin drives it,
  // otherwise the shared clock pin does
  assign ext_level = ctrl.osc_enable ? osc_input_pin
                                     : osc_output_ext_clock_pin;

  // previous level for edge detection; pins are sampled as synchronous
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ext_prev <= 1'b0;
    end else begin
      ext_prev <= ext_level;
    end
  end

  assign ext_rise = ext_level & ~ext_prev;
  assign ext_fall = ~ext_level & ext_prev;
  assign counter_mode_on = ctrl.counter_on & ctrl.clock_source_select;

  // arming: a rising edge that arrives before any falling edge since the
  // counter was enabled would otherwise add a spurious count
  always_ff @(posedge clk) begin
    if (sys_rst || !counter_mode_on) begin
      fall_seen <= 1'b0;
    end else if (ext_fall) begin
      fall_seen <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // prescaler input: instruction ticks or armed rising edges
  always_comb begin
    if (ctrl.clock_source_select) begin
      presc_in = ext_rise & fall_seen;
    end else begin
      presc_in = instr_tick;
    end
  end

  // a stopped timer keeps its prescaler cleared too; a count write restarts it
  assign presc_clear = ~ctrl.counter_on | wr_count;

  sbtc_prescaler u_prescaler (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .clear    (presc_clear),
    .tick_in  (presc_in),
    .select   (ctrl.prescale_select),
    .tick_out (presc_out)
  );

  //////////////////////////////////////////////////////////////////////////
  // sync stage behind the prescaler; costs two cycles of latency, which
  // is the price of lining external counts up with the internal phases
  always_ff @(posedge clk) begin
    if (sys_rst || !ctrl.counter_on) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else begin
      sync_a <= presc_out;
      sync_b <= sync_a;
    end
  end

  // timer mode is always in step, so the sync bit is only looked at in
  // counter mode
  assign use_async = ~ctrl.clock_source_select | ctrl.sync_disable_n;

  always_comb begin
    if (!ctrl.counter_on) begin
      count_tick = 1'b0;
    end else if (use_async) begin
      count_tick = presc_out;
    end else begin
      count_tick = sync_b;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // special event reset from either compare unit; not honoured in the
  // unsynchronised counter mode, where it cannot be relied on
  assign trig_any =
    (capture_compare_unit_a.match &&
     capture_compare_unit_a.mode == SPECIAL_EVENT_MODE) ||
    (capture_compare_unit_b.match &&
     capture_compare_unit_b.mode == SPECIAL_EVENT_MODE);

  assign trig_reset = trig_any & ~(ctrl.clock_source_select &
                                   ctrl.sync_disable_n) &
                      ~wr_count;

  assign wraps = count_tick & (count == COUNT_MAX) &
                 ~wr_count & ~trig_reset;

  //////////////////////////////////////////////////////////////////////////
  // next count: byte write, then special event clear, then increment
  always_comb begin
    next_count = count;
    if (wr_low) begin
      next_count = {count[COUNT_W-1:BYTE_W], pwdata[BYTE_W-1:0]};
    end else if (wr_high) begin
      next_count = {pwdata[BYTE_W-1:0], count[BYTE_W-1:0]};
    end else if (trig_reset) begin
      next_count = COUNT_ZERO;
    end else if (wraps) begin
      next_count = COUNT_ZERO;
    end else if (count_tick) begin
      next_count = count + 1'b1;
    end
  end

  // count register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count <= COUNT_ZERO;
    end else begin
      count <= next_count;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // sticky overflow flag; a wrap in the clearing cycle keeps it set
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      overflow_flag <= 1'b0;
    end else if (wraps) begin
      overflow_flag <= 1'b1;
    end else if (wr_en && paddr == FLAG_CLR_OFS &&
                 pwdata[OVF_BIT]) begin
      overflow_flag <= 1'b0;
    end
  end

  // level request, masked by the enable bit
  assign irq = overflow_flag & overflow_interrupt_enable;

  //////////////////////////////////////////////////////////////////////////
  // read mux; unused upper bits read as zero
  always_comb begin
    rd_value = '0;
    unique case (paddr)
      COUNT_LOW_OFS:  rd_value[BYTE_W-1:0] = count[BYTE_W-1:0];
      COUNT_HIGH_OFS: rd_value[BYTE_W-1:0] =
                        count[COUNT_W-1:BYTE_W];
      FLAG_OFS:       rd_value[OVF_BIT]    = overflow_flag;
      CTRL_OFS:       rd_value[CTRL_W-1:0] = ctrl;
      ENABLE_OFS:     rd_value[OVF_IE_BIT] = overflow_interrupt_enable;
      default:        rd_value = '0;         // clear reg and holes
    endcase
  end

  // read data captured in the setup cycle, stable through the access
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prdata <= '0;
    end else if (rd_setup) begin
      prdata <= rd_value;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // oscillator pins: with the oscillator on, both pins are inputs and the
  // port sees zeros; otherwise the port direction bits rule
  assign osc_inverter_on = ctrl.osc_enable;
  assign pin_out         = port_out_data;

  always_comb begin
    if (ctrl.osc_enable) begin
      pin_oe         = 2'h0;
      port_read_data = 2'h0;
    end else begin
      pin_oe         = ~port_direction_bits;
      port_read_data = {osc_input_pin, osc_output_ext_clock_pin};
    end
  end

endmodule
